// File: hw/pmic_irq_regs.svh
// Purpose: register offsets, field positions and reset values
// Assumes: 8-bit register port, byte offsets
// Notes:   definitions only
`ifndef PMIC_IRQ_REGS_SVH
`define PMIC_IRQ_REGS_SVH

// ==========================================
// offsets
`define OFS_TOP_MASK_A  8'h20
`define OFS_TOP_MASK_B  8'h21
`define OFS_REG_MASK    8'h22
`define OFS_METER_SEL   8'h24
`define OFS_METER_HI    8'h25
`define OFS_METER_LO    8'h26
`define OFS_TOP_FLAG_A  8'h28
`define OFS_TOP_FLAG_B  8'h29
`define OFS_REG_FLAG    8'h2A

// ==========================================
// top mask / flag a fields
`define BIT_PG_EVENT    7
`define BIT_SYNC_CLK    4
`define BIT_THERMAL     2
`define BIT_METER       0
// top mask / flag b fields
`define BIT_REG_RESET   0
// regulator mask / flag fields, then the meter select field
`define BIT_R2_PG_FALL  7
`define BIT_R2_PG_RISE  6
`define BIT_R2_PG       6
`define BIT_R2_LIMIT    4
`define BIT_R1_PG_FALL  3
`define BIT_R1_PG_RISE  2
`define BIT_R1_PG       2
`define BIT_R1_LIMIT    0
`define BIT_SELECT      0

// ==========================================
// writable-bit masks and reset values
`define WMASK_TOP_A     8'hFF
`define WMASK_TOP_B     8'hFF
`define WMASK_REG       8'hDD
`define WMASK_SEL       8'hFF
`define RST_MASK_ALL    8'hFF
`define RST_ZERO        8'h00
`define RST_RESULT      9'h000

`endif

// File: hw/pmic_irq_pkg.sv
// Purpose: types shared by the mask and load meter block
// Assumes: nothing
// Notes:   one-hot meter sequencer states
package pmic_irq_pkg;

	// ==========================================
	// meter sequencer
	typedef enum logic [2:0] {
		meter_idle = 3'h1,
		meter_busy = 3'h2,
		meter_post = 3'h4
	} meter_state_type;

endpackage : pmic_irq_pkg

// File: hw/pmic_irq_mask_and_load_meter.sv
// Purpose: interrupt masks, latched flags and load meter trigger
// Assumes: register port driven by the serial front end, one
//          access per cycle; all inputs synchronous to ref_clk
// Notes:   masks gate only the interrupt output, never flags or
//          raw state
//          a mask write in a reload cycle is lost
// Contract
// [RULE_01] top mask a bit 7 gates the power-good event; 1 blocks.
// [RULE_02] masks touch only the interrupt; raw state stays true.
// [RULE_03] top mask a bit 4 gates clock detection interrupt.
// [RULE_04] top mask a bit 2 gates thermal warning interrupt.
// [RULE_05] top mask a bit 0 gates measurement ready interrupt.
// [RULE_06] top mask b bit 0 gates register reset; 7:1 reserved.
// [RULE_07] register reset reloads that mask bit from otp.
// [RULE_08] regulator mask bit 7 gates second buck falling pg.
// [RULE_09] regulator mask bit 6 gates second buck rising pg.
// [RULE_10] regulator mask bit 4 gates second buck current limit.
// [RULE_11] regulator mask bit 3 gates first buck falling pg.
// [RULE_12] regulator mask bit 2 gates first buck rising pg.
// [RULE_13] bit 0 gates first buck limit; bits 5,1 read zero.
// [RULE_14] select bit 0 picks buck measured; resets to first.
// [RULE_15] any write of the select register starts a measurement.
// [RULE_16] flags latch on events, cleared by writing one.
// [RULE_17] result is 9 bits, 20 mA step, low byte at 0x26.
// [RULE_18] interrupt high while any unmasked flag is set.
// [RULE_19] on completion, update result, then set ready flag.
// [RULE_20] mask reset values come from otp configuration.
`include "pmic_irq_regs.svh"

module pmic_irq_mask_and_load_meter
	import pmic_irq_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// otp configuration
	input  wire logic [7:0] otp_top_mask_a,
	input  wire logic [7:0] otp_top_mask_b,
	input  wire logic [7:0] otp_reg_mask,
	input  wire logic       reg_reset_event,
	// raw state
	input  wire logic       power_good_pin_state,
	input  wire logic       sync_clk_state,
	input  wire logic       thermal_warning_state,
	input  wire logic       first_reg_pg_state,
	input  wire logic       second_reg_pg_state,
	input  wire logic       first_reg_limit_state,
	input  wire logic       second_reg_limit_state,
	// load meter
	input  wire logic       meter_done,
	input  wire logic [8:0] meter_result,
	output logic            meter_start,
	output logic            meter_buck_select,
	output logic            irq_out
);

	// ==========================================
	// declarations
	logic [7:0]      top_interrupt_mask_a;
	logic [7:0]      top_interrupt_mask_b;
	logic [7:0]      regulator_interrupt_mask;
	logic [7:0]      load_meter_select;
	logic [8:0]      load_result;
	logic [7:0]      top_flag_a;
	logic [7:0]      top_flag_b;
	logic [7:0]      reg_flag;
	logic [3:0]      pg_sub;
	logic [6:0]      prev_state;
	logic            otp_load;
	meter_state_type meter_state;
	// combinational terms
	logic [6:0]      raw_now;
	logic [7:0]      set_top_a;
	logic [7:0]      set_top_b;
	logic [7:0]      set_reg;
	logic [3:0]      set_sub;
	logic            wr_top_a;
	logic            wr_top_b;
	logic            wr_reg;
	logic            wr_sel;
	logic            wr_flag_a;
	logic            wr_flag_b;
	logic            wr_flag_r;
	logic            meter_set;
	logic            next_irq;
	logic [7:0]      next_rdata;

	// ==========================================
	// write decode
	// unmapped offsets decode to nothing, so such writes are lost
	assign wr_top_a  = reg_wr && (reg_addr == `OFS_TOP_MASK_A);
	assign wr_top_b  = reg_wr && (reg_addr == `OFS_TOP_MASK_B);
	assign wr_reg    = reg_wr && (reg_addr == `OFS_REG_MASK);
	assign wr_sel    = reg_wr && (reg_addr == `OFS_METER_SEL);
	assign wr_flag_a = reg_wr && (reg_addr == `OFS_TOP_FLAG_A);
	assign wr_flag_b = reg_wr && (reg_addr == `OFS_TOP_FLAG_B);
	assign wr_flag_r = reg_wr && (reg_addr == `OFS_REG_FLAG);

	// ==========================================
	// otp capture: masks load on the first edge after reset
	// release; a register reset event reloads them at its own
	// edge, the same edge that sets its flag, so a stale host
	// value never opens a gate for even one cycle
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			otp_load <= 1'b1;
		end else begin
			otp_load <= 1'b0;
		end
	end

	// ==========================================
	// top mask a: reset masks everything until otp arrives
	// reserved bits store what is written and gate nothing
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			top_interrupt_mask_a <= `RST_MASK_ALL;
		end else if (otp_load || reg_reset_event) begin
			top_interrupt_mask_a <= otp_top_mask_a;  // [RULE_20]
		end else if (wr_top_a) begin
			top_interrupt_mask_a <= reg_wdata & `WMASK_TOP_A;
		end
	end

	// ==========================================
	// top mask b: a host write lasts only until the next reload
	// bits 7:1 are plain storage with no function
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			top_interrupt_mask_b <= `RST_MASK_ALL;
		end else if (otp_load || reg_reset_event) begin
			top_interrupt_mask_b <= otp_top_mask_b;  // [RULE_07]
		end else if (wr_top_b) begin
			top_interrupt_mask_b <= reg_wdata & `WMASK_TOP_B;
		end
	end

	// ==========================================
	// regulator mask: reserved bits forced to zero
	// on every path, otp load included, so they always read zero
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			regulator_interrupt_mask <= `RST_MASK_ALL & `WMASK_REG;
		end else if (otp_load || reg_reset_event) begin
			regulator_interrupt_mask <= otp_reg_mask & `WMASK_REG;
		end else if (wr_reg) begin
			regulator_interrupt_mask <= reg_wdata & `WMASK_REG; // [RULE_13]
		end
	end

	// ==========================================
	// load meter select; each write is a start request
	// the whole byte is stored but only bit 0 steers the meter
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			load_meter_select <= `RST_ZERO;               // [RULE_14]
			meter_start       <= 1'b0;
			meter_buck_select <= 1'b0;
		end else begin
			meter_start <= wr_sel;                        // [RULE_15]
			if (wr_sel) begin
				load_meter_select <= reg_wdata & `WMASK_SEL;
				meter_buck_select <= reg_wdata[`BIT_SELECT]; // [RULE_14]
			end
		end
	end

	// ==========================================
	// meter sequencer: result first, ready flag one cycle later
	// so software never sees the flag ahead of the data
	// a meter_done that comes while idle is dropped
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meter_state <= meter_idle;
			load_result <= `RST_RESULT;
		end else begin
			case (meter_state)
				meter_idle: begin
					if (wr_sel) begin
						meter_state <= meter_busy;
					end
				end
				meter_busy: begin
					if (meter_done) begin
						load_result <= meter_result;     // [RULE_17]
						meter_state <= meter_post;       // [RULE_19]
					end
				end
				meter_post: begin
					// a write here restarts without losing this result
					meter_state <= wr_sel ? meter_busy : meter_idle;
				end
				default: begin
					meter_state <= meter_idle;
				end
			endcase
		end
	end

	// ready pulse one edge behind the result capture
	assign meter_set = (meter_state == meter_post);   // [RULE_19]

	// ==========================================
	// event detection on raw state; masks are not consulted
	assign raw_now = {power_good_pin_state, sync_clk_state,
		thermal_warning_state, first_reg_pg_state,
		second_reg_pg_state, first_reg_limit_state,
		second_reg_limit_state};

	// previous raw levels; they start at zero, so inputs already
	// active at reset release look like fresh events
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_state <= 7'h00;
		end else begin
			prev_state <= raw_now;                       // [RULE_02]
		end
	end

	// pg state is 1 when invalid: 0->1 falls, 1->0 rises
	// thermal and limit events take rising edges only
	always_comb begin
		set_top_a = 8'h00;
		set_top_b = 8'h00;
		set_reg   = 8'h00;
		set_sub   = 4'h0;
		set_top_a[`BIT_PG_EVENT] = raw_now[6] ^ prev_state[6];
		set_top_a[`BIT_SYNC_CLK] = raw_now[5] ^ prev_state[5];
		set_top_a[`BIT_THERMAL]  = raw_now[4] & ~prev_state[4];
		set_top_a[`BIT_METER]    = meter_set;
		set_top_b[`BIT_REG_RESET] = reg_reset_event;
		set_sub[0] = raw_now[3] & ~prev_state[3];  // first falls
		set_sub[1] = ~raw_now[3] & prev_state[3];  // first rises
		set_sub[2] = raw_now[2] & ~prev_state[2];  // second falls
		set_sub[3] = ~raw_now[2] & prev_state[2];  // second rises
		set_reg[`BIT_R1_PG]    = set_sub[0] | set_sub[1];
		set_reg[`BIT_R2_PG]    = set_sub[2] | set_sub[3];
		set_reg[`BIT_R1_LIMIT] = raw_now[1] & ~prev_state[1];
		set_reg[`BIT_R2_LIMIT] = raw_now[0] & ~prev_state[0];
	end

	// ==========================================
	// latched flags: write one clears, a same-cycle event wins
	// so an event is never lost to a late clear
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			top_flag_a <= `RST_ZERO;
			top_flag_b <= `RST_ZERO;
			reg_flag   <= `RST_ZERO;
		end else begin
			top_flag_a <= (top_flag_a
				& ~(wr_flag_a ? reg_wdata : 8'h00)) | set_top_a; // [RULE_16]
			top_flag_b <= (top_flag_b
				& ~(wr_flag_b ? reg_wdata : 8'h00)) | set_top_b; // [RULE_16]
			reg_flag   <= (reg_flag
				& ~(wr_flag_r ? reg_wdata : 8'h00)) | set_reg;   // [RULE_16]
		end
	end

	// which pg transition raised each regulator flag; cleared
	// together with the flag so the two edge masks apply apart
	// a new transition in the clear cycle still wins
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pg_sub <= 4'h0;
		end else begin
			pg_sub[1:0] <= (pg_sub[1:0] & ~{2{wr_flag_r
				&& reg_wdata[`BIT_R1_PG]}}) | set_sub[1:0];
			pg_sub[3:2] <= (pg_sub[3:2] & ~{2{wr_flag_r
				&& reg_wdata[`BIT_R2_PG]}}) | set_sub[3:2];
		end
	end

	// ==========================================
	// interrupt: any flag whose gate is open
	// a flag latched behind a closed gate raises the pin as soon
	// as the gate opens
	always_comb begin
		next_irq =
			(top_flag_a[`BIT_PG_EVENT]
				& ~top_interrupt_mask_a[`BIT_PG_EVENT])     // [RULE_01]
			| (top_flag_a[`BIT_SYNC_CLK]
				& ~top_interrupt_mask_a[`BIT_SYNC_CLK])     // [RULE_03]
			| (top_flag_a[`BIT_THERMAL]
				& ~top_interrupt_mask_a[`BIT_THERMAL])      // [RULE_04]
			| (top_flag_a[`BIT_METER]
				& ~top_interrupt_mask_a[`BIT_METER])        // [RULE_05]
			| (top_flag_b[`BIT_REG_RESET]
				& ~top_interrupt_mask_b[`BIT_REG_RESET])    // [RULE_06]
			| (pg_sub[2]
				& ~regulator_interrupt_mask[`BIT_R2_PG_FALL]) // [RULE_08]
			| (pg_sub[3]
				& ~regulator_interrupt_mask[`BIT_R2_PG_RISE]) // [RULE_09]
			| (reg_flag[`BIT_R2_LIMIT]
				& ~regulator_interrupt_mask[`BIT_R2_LIMIT])   // [RULE_10]
			| (pg_sub[0]
				& ~regulator_interrupt_mask[`BIT_R1_PG_FALL]) // [RULE_11]
			| (pg_sub[1]
				& ~regulator_interrupt_mask[`BIT_R1_PG_RISE]) // [RULE_12]
			| (reg_flag[`BIT_R1_LIMIT]
				& ~regulator_interrupt_mask[`BIT_R1_LIMIT]);  // [RULE_13]
	end

	// registered so decode glitches never reach the pin
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= next_irq;                         // [RULE_18]
		end
	end

	// ==========================================
	// read mux; unmapped addresses read zero
	// reads have no side effect: flags clear only by writing one
	always_comb begin
		case (reg_addr)
			`OFS_TOP_MASK_A: next_rdata = top_interrupt_mask_a;
			`OFS_TOP_MASK_B: next_rdata = top_interrupt_mask_b;
			`OFS_REG_MASK:   next_rdata = regulator_interrupt_mask;
			`OFS_METER_SEL:  next_rdata = load_meter_select;
			`OFS_METER_HI:   next_rdata = {7'h00, load_result[8]};
			`OFS_METER_LO:   next_rdata = load_result[7:0]; // [RULE_17]
			`OFS_TOP_FLAG_A: next_rdata = top_flag_a;
			`OFS_TOP_FLAG_B: next_rdata = top_flag_b;
			`OFS_REG_FLAG:   next_rdata = reg_flag;
			default:         next_rdata = 8'h00;
		endcase
	end

	// read data holds until the next read strobe
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= `RST_ZERO;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

endmodule : pmic_irq_mask_and_load_meter

// File: dv/irq_meter_checker.sv
// Purpose: port assertions for the mask and load meter block
// Assumes: one clock, async active-high reset
// Notes:   flags and masks are internal, so only port relations
module irq_meter_checker
(
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       meter_start,
	input wire logic       meter_buck_select
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// ==========================================
	// meter trigger
	start_cause_a: assert property (
		meter_start == $past(reg_wr && reg_addr == 8'h24))
		else $error("start pulse does not follow select write");
	select_load_a: assert property (
		reg_wr && reg_addr == 8'h24 |=>
		meter_buck_select == $past(reg_wdata[0]))
		else $error("select not taken from written bit");
	select_hold_a: assert property (
		!(reg_wr && reg_addr == 8'h24) |=> $stable(meter_buck_select))
		else $error("select moved without a write");

	// ==========================================
	// read data
	pg_res_zero_a: assert property (
		reg_rd && reg_addr == 8'h22 |-> ##1 (reg_rdata & 8'h22) == 8'h00)
		else $error("reserved gate bits read nonzero");
	hi_res_zero_a: assert property (
		reg_rd && reg_addr == 8'h25 |=> reg_rdata[7:1] == 7'h00)
		else $error("result high byte upper bits nonzero");
	rdata_stand_a: assert property (
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	flag_b_res_a: assert property (
		reg_rd && reg_addr == 8'h29 |=> reg_rdata[7:1] == 7'h00)
		else $error("unused top flag b bits nonzero");
	flag_r_res_a: assert property (
		reg_rd && reg_addr == 8'h2A |=> (reg_rdata & 8'hAA) == 8'h00)
		else $error("unused regulator flag bits nonzero");
endmodule : irq_meter_checker

bind pmic_irq_mask_and_load_meter irq_meter_checker chk (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .meter_start(meter_start),
	.meter_buck_select(meter_buck_select));

// File: dv/meter_model.sv
// Purpose: load meter front end answering each start pulse
// Assumes: start is a one-cycle pulse
// Notes:   result keeps moving outside the done cycle
module meter_model #(
	parameter logic [8:0] RES_A = 9'h05C,
	parameter logic [8:0] RES_B = 9'h1A5
) (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       meter_start,
	input  wire logic       meter_buck_select,
	output logic            meter_done,
	output logic      [8:0] meter_result
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	// a new start restarts the count; stale data never holds still
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 0;
			meter_done <= 1'h0;
			meter_result <= 9'h1FF;
		end else begin
			meter_done <= !meter_start && cnt == 1;
			if (!meter_start && cnt == 1) begin
				meter_result <= meter_buck_select ? RES_B : RES_A;
			end else begin
				meter_result <= ~meter_result;
			end
			if (meter_start) begin
				cnt <= 6;
			end else if (cnt > 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule : meter_model

// File: dv/pmic_irq_mask_and_load_meter_test.sv
// Purpose: register-level test of the mask and load meter block
// Assumes: meter_model answers each start within 20 cycles
// Notes:   events come from toggling the raw state inputs
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
	n_fail++; $display("ERROR %0t got %h exp %h", $time, g, e); end end

module pmic_irq_mask_and_load_meter_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [8:0] RES_A = 9'h05C;
	localparam logic [8:0] RES_B = 9'h1A5;
	// flag addr, flag bit, gate bit, raw index, preset level
	localparam logic [23:0] EV [9] = '{
		24'h287700, 24'h284410, 24'h282220,
		24'h2A2330, 24'h2A2231, 24'h2A6740,
		24'h2A6641, 24'h2A0050, 24'h2A4460};
	logic       ref_clk, sys_rst, reg_wr, reg_rd, reg_reset_event;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, otp_a, otp_b, otp_r, fa, m;
	logic [3:0] fb, mb, r, k;
	logic [6:0] raw;
	logic       meter_start, meter_buck_select, irq_out, meter_done;
	logic [8:0] meter_result;
	logic [8:0] res [2] = '{RES_A, RES_B};
	int         n_fail, total_checks;

	pmic_irq_mask_and_load_meter DUT (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .otp_top_mask_a(otp_a),
		.otp_top_mask_b(otp_b), .otp_reg_mask(otp_r),
		.reg_reset_event(reg_reset_event),
		.power_good_pin_state(raw[0]), .sync_clk_state(raw[1]),
		.thermal_warning_state(raw[2]), .first_reg_pg_state(raw[3]),
		.second_reg_pg_state(raw[4]), .first_reg_limit_state(raw[5]),
		.second_reg_limit_state(raw[6]), .meter_done(meter_done),
		.meter_result(meter_result), .meter_start(meter_start),
		.meter_buck_select(meter_buck_select), .irq_out(irq_out));

	meter_model #(.RES_A(RES_A), .RES_B(RES_B)) partner (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .meter_start(meter_start),
		.meter_buck_select(meter_buck_select), .meter_done(meter_done),
		.meter_result(meter_result));

	// ==========================================
	// register port tasks, entered just after a rising edge
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : idle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		idle(1);
		reg_wr <= 1'h0;
		idle(1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'h1;
		idle(1);
		reg_rd <= 1'h0;
		idle(1);
		`CHK(reg_rdata, e)
	endtask : rd
	task automatic kick;
		reg_reset_event <= 1'h1;
		idle(1);
		reg_reset_event <= 1'h0;
		idle(1);
	endtask : kick
	task automatic give_verdict;
		if (n_fail == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict

	// ==========================================
	// clock and watchdog, about forty times the expected run
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		#200us;
		n_fail++;
		give_verdict();
	end

	// main sequence
	initial begin
		{sys_rst, reg_wr, reg_rd, reg_reset_event} = 4'h8;
		{reg_addr, reg_wdata, raw, otp_b} = '0;
		otp_b = 8'h01;
		otp_a = 8'h95;
		otp_r = 8'h7E;
		n_fail = 0;
		total_checks = 0;
		idle(5);
		sys_rst <= 1'h0;
		idle(2);
		rd(8'h20, 8'h95);
		rd(8'h22, 8'h5C);
		rd(8'h24, 8'h00);
		wr(8'h22, 8'hFF);
		rd(8'h22, 8'hDD);
		// each source: masked event latches, unmasked event interrupts
		foreach (EV[i]) begin
			{fa, fb, mb, r, k} = EV[i];
			m = fa - 8'h08;
			wr(8'h20, 8'hFF);
			wr(8'h22, 8'hFF);
			raw[r] <= k[0];
			idle(2);
			wr(8'h28, 8'hFF);
			wr(8'h2A, 8'hFF);
			raw[r] <= ~k[0];
			idle(3);
			rd(fa, 8'h01 << fb);
			`CHK(irq_out, 1'h0)
			wr(fa, 8'h01 << fb);
			rd(fa, 8'h00);
			wr(m, ~(8'h01 << mb));
			raw[r] <= k[0];
			idle(3);
			wr(fa, 8'h01 << fb);
			idle(3);
			`CHK(irq_out, 1'h0)
			raw[r] <= ~k[0];
			idle(3);
			`CHK(irq_out, 1'h1)
			wr(fa, 8'h01 << fb);
			idle(3);
			`CHK(irq_out, 1'h0)
			raw[r] <= 1'h0;
			idle(2);
		end
		// measurement on each regulator, masked then unmasked
		for (int s = 0; s < 2; s++) begin
			wr(8'h20, s ? 8'hFE : 8'hFF);
			wr(8'h24, s[7:0]);
			idle(20);
			`CHK(meter_buck_select, s[0])
			`CHK(irq_out, s[0])
			rd(8'h26, res[s][7:0]);
			rd(8'h25, {7'h00, res[s][8]});
			rd(8'h28, 8'h01);
			rd(8'h24, s[7:0]);
			wr(8'h28, 8'h01);
		end
		// host value of the reset gate is lost on register reset
		wr(8'h21, 8'h00);
		rd(8'h21, 8'h00);
		kick();
		idle(1);
		`CHK(irq_out, 1'h0)
		rd(8'h21, 8'h01);
		rd(8'h29, 8'h01);
		`CHK(irq_out, 1'h0)
		otp_b <= 8'h00;
		wr(8'h29, 8'h01);
		kick();
		idle(3);
		`CHK(irq_out, 1'h1)
		wr(8'h29, 8'h01);
		idle(3);
		`CHK(irq_out, 1'h0)
		give_verdict();
	end
endmodule : pmic_irq_mask_and_load_meter_test
